// ### core/pemx_defs.svh
// Register offsets, field positions, pin numbers and reset values of the port E and ready pin multiplexer.
`ifndef PEMX_DEFS_SVH
`define PEMX_DEFS_SVH
`define PEMX_OFF_FUNC_SEL     12'h000
`define PEMX_OFF_PORT_OUT     12'h004
`define PEMX_OFF_PORT_OE      12'h008
`define PEMX_OFF_PORT_IN      12'h00c
`define PEMX_OFF_IF_CONFIG    12'h010
`define PEMX_OFF_FIFO_POL     12'h014
`define PEMX_OFF_TIMER2_CTRL  12'h018
`define PEMX_OFF_STATUS       12'h01c
`define PEMX_FUNC_SEL_RST     8'h00
`define PEMX_IF_CONFIG_RST    8'h00
`define PEMX_FIFO_POL_RST     8'h00
`define PEMX_IFMODE_LSB       0
`define PEMX_IFMODE_MSB       1
`define PEMX_POL_RD_BIT       3
`define PEMX_POL_WR_BIT       2
`define PEMX_T2_EXEN_BIT      3
`define PEMX_PIN_T2OVF        2
`define PEMX_PIN_SER0         3
`define PEMX_PIN_SER1         4
`define PEMX_PIN_IRQ6         5
`define PEMX_PIN_T2RLD        6
`define PEMX_PIN_ADDR8        7
`endif

// ### core/pemx_pkg.sv
// Types shared by the port E and ready pin multiplexer.
package pemx_pkg;
    typedef enum logic [1:0] {
        PEMX_IF_PORTS = 2'h0,
        PEMX_IF_RSVD  = 2'h1,
        PEMX_IF_WAVE  = 2'h2,
        PEMX_IF_SLAVE = 2'h3
    } pemx_ifmode_t;
    typedef logic [1:0] pemx_sermode_t;
endpackage

// ### core/pemx_edge_det.sv
// Registered edge detector for one synchronous input.
`timescale 1ns/1ps
module pemx_edge_det (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic sig_i,
    output logic      rise_o,
    output logic      fall_o
);
    logic last_ff;
    logic nxt_last;

    always_comb begin
        nxt_last = sig_i;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            last_ff <= 1'b0;
        end else begin
            last_ff <= nxt_last;
        end
    end

    assign rise_o = sig_i & ~last_ff;
    assign fall_o = ~sig_i & last_ff;
endmodule

// ### core/pemx_apb_regs.sv
// APB slave holding the multiplexer's software registers.
`timescale 1ns/1ps
`include "pemx_defs.svh"
module pemx_apb_regs (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [7:0]  port_in_i,
    input  wire logic [7:0]  status_i,
    output logic      [7:0]  func_sel_o,
    output logic      [7:0]  port_out_o,
    output logic      [7:0]  port_oe_o,
    output logic      [7:0]  if_config_o,
    output logic      [7:0]  fifo_pol_o,
    output logic      [7:0]  t2_ctrl_o
);
    logic [7:0] func_ff, out_ff, oe_ff, ifc_ff, pol_ff, t2c_ff;
    logic [7:0] nxt_func, nxt_out, nxt_oe, nxt_ifc, nxt_pol, nxt_t2c;
    logic       hit;
    logic [7:0] rd;
    logic       wr;

    always_comb begin
        hit = 1'b1;
        rd  = 8'h00;
        unique case (paddr_i)
            `PEMX_OFF_FUNC_SEL:    rd = func_ff;
            `PEMX_OFF_PORT_OUT:    rd = out_ff;
            `PEMX_OFF_PORT_OE:     rd = oe_ff;
            `PEMX_OFF_PORT_IN:     rd = port_in_i;
            `PEMX_OFF_IF_CONFIG:   rd = ifc_ff;
            `PEMX_OFF_FIFO_POL:    rd = pol_ff;
            `PEMX_OFF_TIMER2_CTRL: rd = t2c_ff;
            `PEMX_OFF_STATUS:      rd = status_i;
            default:               hit = 1'b0;
        endcase
    end

    assign wr        = psel_i & penable_i & pwrite_i;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~hit;
    assign prdata_o  = {24'h000000, rd};

    always_comb begin
        nxt_func = func_ff;
        nxt_out  = out_ff;
        nxt_oe   = oe_ff;
        nxt_ifc  = ifc_ff;
        nxt_pol  = pol_ff;
        nxt_t2c  = t2c_ff;
        if (wr) begin
            unique case (paddr_i)
                `PEMX_OFF_FUNC_SEL:    nxt_func = {pwdata_i[7:2], 2'b00}; // [RULE_01]
                `PEMX_OFF_PORT_OUT:    nxt_out  = pwdata_i[7:0];
                `PEMX_OFF_PORT_OE:     nxt_oe   = pwdata_i[7:0];
                `PEMX_OFF_IF_CONFIG:   nxt_ifc  = pwdata_i[7:0];
                `PEMX_OFF_FIFO_POL:    nxt_pol  = pwdata_i[7:0];
                `PEMX_OFF_TIMER2_CTRL: nxt_t2c  = pwdata_i[7:0];
                default: ;
            endcase
        end
    end

    // Everything comes up as a port input with no alternate selected.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            func_ff <= `PEMX_FUNC_SEL_RST; // [RULE_13]
            out_ff  <= 8'h00;
            oe_ff   <= 8'h00; // [RULE_13]
            ifc_ff  <= `PEMX_IF_CONFIG_RST;
            pol_ff  <= `PEMX_FIFO_POL_RST;
            t2c_ff  <= 8'h00;
        end else begin
            func_ff <= nxt_func;
            out_ff  <= nxt_out;
            oe_ff   <= nxt_oe;
            ifc_ff  <= nxt_ifc;
            pol_ff  <= nxt_pol;
            t2c_ff  <= nxt_t2c;
        end
    end

    assign func_sel_o  = func_ff;
    assign port_out_o  = out_ff;
    assign port_oe_o   = oe_ff;
    assign if_config_o = ifc_ff;
    assign fifo_pol_o  = pol_ff;
    assign t2_ctrl_o   = t2c_ff;
endmodule

// ### core/pemx_port_e_mux.sv
// Port E upper pin function multiplexer and ready pin router.
// How it works
// [RULE_01] Config bit n picks port or alternate.
// [RULE_02] Timer-2 overflow drives one-cycle high pulse.
// [RULE_03] Serial-0 data only in mode 0, else 1.
// [RULE_04] Serial-1 data only in mode 0, else high.
// [RULE_05] Interrupt six: rising edge request to core.
// [RULE_06] Reload pin falling edge reloads timer 2, if enabled.
// [RULE_07] Pin 7 alternate drives waveform address bit 8.
// [RULE_08] Interface mode picks ready or slave strobes.
// [RULE_09] Ready 0 is read strobe, polarity bit 3.
// [RULE_10] Ready 1 is write strobe, polarity bit 2.
// [RULE_11] Ready 2..5 go straight to waveform engine.
// [RULE_12] Strobes and ready sampled on interface clock.
// [RULE_13] Reset leaves all upper pins as inputs.
`timescale 1ns/1ps
`include "pemx_defs.svh"
module pemx_port_e_mux #(
    parameter int PORT_W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [11:0]       paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    input  wire logic [PORT_W-1:0] port_e_pin_i,
    output logic      [PORT_W-1:0] port_e_pin_o,
    output logic      [PORT_W-1:0] port_e_pin_oe_o,
    input  wire logic              timer2_overflow_i,
    input  wire logic              serial0_data_i,
    input  wire logic [1:0]        serial0_mode_i,
    input  wire logic              serial1_data_i,
    input  wire logic [1:0]        serial1_mode_i,
    input  wire logic              waveform_addr_bit8_i,
    output logic                   ext_irq_six_o,
    output logic                   timer2_reload_o,
    input  wire logic [5:0]        ready_in_i,
    output logic      [5:0]        waveform_ready_o,
    output logic                   slave_read_strobe_o,
    output logic                   slave_write_strobe_o
);
    // The pin map below is fixed to eight pins, so any other width is refused.
    if (PORT_W != 8) begin : g_port_w_check
        $error("PORT_W must be 8");
    end

    logic [7:0] func_sel, port_out, port_oe, if_config, fifo_pol, t2_ctrl, status;
    logic       irq_rise, irq_fall, rld_rise, rld_fall;
    pemx_pkg::pemx_ifmode_t if_mode;
    logic       slave_mode;

    pemx_apb_regs u_regs (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .psel_i     (psel_i),
        .penable_i  (penable_i),
        .pwrite_i   (pwrite_i),
        .paddr_i    (paddr_i),
        .pwdata_i   (pwdata_i),
        .prdata_o   (prdata_o),
        .pready_o   (pready_o),
        .pslverr_o  (pslverr_o),
        .port_in_i  (port_e_pin_i),
        .status_i   (status),
        .func_sel_o (func_sel),
        .port_out_o (port_out),
        .port_oe_o  (port_oe),
        .if_config_o(if_config),
        .fifo_pol_o (fifo_pol),
        .t2_ctrl_o  (t2_ctrl)
    );

    // Edges are taken on the raw pin and gated by the selection afterwards, so
    // selecting the alternate while the pin is held high never counts as an edge.
    pemx_edge_det u_irq6 (
        .clk_i  (clk_i),
        .rst_b_i(rst_b_i),
        .sig_i  (port_e_pin_i[`PEMX_PIN_IRQ6]),
        .rise_o (irq_rise),
        .fall_o (irq_fall)
    );

    pemx_edge_det u_t2rld (
        .clk_i  (clk_i),
        .rst_b_i(rst_b_i),
        .sig_i  (port_e_pin_i[`PEMX_PIN_T2RLD]),
        .rise_o (rld_rise),
        .fall_o (rld_fall)
    );

    logic [7:0] pin_ff, nxt_pin, oe_ff, nxt_oe;
    logic       irq_ff, nxt_irq, rld_ff, nxt_rld;

    always_comb begin
        nxt_pin = port_out;
        nxt_oe  = port_oe;
        nxt_pin[1:0] = port_out[1:0];
        if (func_sel[`PEMX_PIN_T2OVF]) begin // [RULE_01]
            nxt_pin[`PEMX_PIN_T2OVF] = timer2_overflow_i; // [RULE_02]
            nxt_oe[`PEMX_PIN_T2OVF]  = 1'b1;
        end
        if (func_sel[`PEMX_PIN_SER0]) begin
            nxt_pin[`PEMX_PIN_SER0] = (serial0_mode_i == 2'h0) ? serial0_data_i : 1'b1; // [RULE_03]
            nxt_oe[`PEMX_PIN_SER0]  = 1'b1;
        end
        if (func_sel[`PEMX_PIN_SER1]) begin
            nxt_pin[`PEMX_PIN_SER1] = (serial1_mode_i == 2'h0) ? serial1_data_i : 1'b1; // [RULE_04]
            nxt_oe[`PEMX_PIN_SER1]  = 1'b1;
        end
        if (func_sel[`PEMX_PIN_IRQ6]) begin
            nxt_pin[`PEMX_PIN_IRQ6] = 1'b0; // [RULE_05]
            nxt_oe[`PEMX_PIN_IRQ6]  = 1'b0;
        end
        if (func_sel[`PEMX_PIN_T2RLD]) begin
            nxt_pin[`PEMX_PIN_T2RLD] = 1'b0; // [RULE_06]
            nxt_oe[`PEMX_PIN_T2RLD]  = 1'b0;
        end
        if (func_sel[`PEMX_PIN_ADDR8]) begin
            nxt_pin[`PEMX_PIN_ADDR8] = waveform_addr_bit8_i; // [RULE_07]
            nxt_oe[`PEMX_PIN_ADDR8]  = 1'b1;
        end
        nxt_irq = irq_rise & func_sel[`PEMX_PIN_IRQ6]; // [RULE_05]
        nxt_rld = rld_fall & func_sel[`PEMX_PIN_T2RLD] & t2_ctrl[`PEMX_T2_EXEN_BIT]; // [RULE_06]
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_ff <= 8'h00;
            oe_ff  <= 8'h00; // [RULE_13]
            irq_ff <= 1'b0;
            rld_ff <= 1'b0;
        end else begin
            pin_ff <= nxt_pin;
            oe_ff  <= nxt_oe;
            irq_ff <= nxt_irq;
            rld_ff <= nxt_rld;
        end
    end

    assign port_e_pin_o    = pin_ff;
    assign port_e_pin_oe_o = oe_ff;
    assign ext_irq_six_o   = irq_ff;
    assign timer2_reload_o = rld_ff;

    // The ready pins are taken as already timed to the interface clock, which
    // is clk_i here; only the strobes' routing and polarity live in this block.
    assign if_mode    = pemx_pkg::pemx_ifmode_t'(if_config[`PEMX_IFMODE_MSB:`PEMX_IFMODE_LSB]); // [RULE_08]
    assign slave_mode = (if_mode == pemx_pkg::PEMX_IF_SLAVE); // [RULE_08]

    logic [5:0] rdy_ff, nxt_rdy;
    logic       srd_ff, nxt_srd, swr_ff, nxt_swr;

    always_comb begin
        nxt_rdy      = ready_in_i; // [RULE_11]
        nxt_srd      = 1'b0;
        nxt_swr      = 1'b0;
        if (slave_mode) begin
            nxt_rdy[1:0] = 2'b00;
            nxt_srd = ready_in_i[0] ~^ fifo_pol[`PEMX_POL_RD_BIT]; // [RULE_09]
            nxt_swr = ready_in_i[1] ~^ fifo_pol[`PEMX_POL_WR_BIT]; // [RULE_10]
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin // [RULE_12]
        if (!rst_b_i) begin
            rdy_ff <= 6'h00;
            srd_ff <= 1'b0;
            swr_ff <= 1'b0;
        end else begin
            rdy_ff <= nxt_rdy;
            srd_ff <= nxt_srd;
            swr_ff <= nxt_swr;
        end
    end

    assign waveform_ready_o     = rdy_ff;
    assign slave_read_strobe_o  = srd_ff;
    assign slave_write_strobe_o = swr_ff;
    assign status = {5'h00, slave_mode, irq_fall, rld_rise};

    a_t2_pulse: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_02]
        func_sel[2] && $past(func_sel[2])
        |-> port_e_pin_o[2] == $past(timer2_overflow_i))
        else $error("overflow pin wrong");
    a_t2_enable: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_02]
        $past(func_sel[2])
        |-> port_e_pin_oe_o[2])
        else $error("overflow pin not driven");
    a_ser0_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_03]
        $past(func_sel[3]) && $past(serial0_mode_i) != 2'h0
        |-> port_e_pin_o[3] && port_e_pin_oe_o[3])
        else $error("serial0 pin not high");
    a_ser0_data: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_03]
        $past(func_sel[3]) && $past(serial0_mode_i) == 2'h0
        |-> port_e_pin_o[3] == $past(serial0_data_i))
        else $error("serial0 data wrong");
    a_ser1_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_04]
        $past(func_sel[4]) && $past(serial1_mode_i) != 2'h0
        |-> port_e_pin_o[4])
        else $error("serial1 pin not high");
    a_ser1_data: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_04]
        $past(func_sel[4]) && $past(serial1_mode_i) == 2'h0
        |-> port_e_pin_o[4] == $past(serial1_data_i))
        else $error("serial1 data wrong");
    a_ser1_enable: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_04]
        $past(func_sel[4])
        |-> port_e_pin_oe_o[4])
        else $error("serial1 pin not driven");
    a_irq_edge: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_05]
        func_sel[5] && port_e_pin_i[5] && $past(func_sel[5]) && !$past(port_e_pin_i[5])
        |=> ext_irq_six_o)
        else $error("irq six missed");
    a_irq_cause: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_05]
        ext_irq_six_o
        |-> $past(func_sel[5]) && $past(port_e_pin_i[5]))
        else $error("irq six without cause");
    a_irq_single: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_05]
        ext_irq_six_o
        |=> !ext_irq_six_o)
        else $error("irq six longer than one cycle");
    a_irq_input: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_05]
        $past(func_sel[5])
        |-> !port_e_pin_oe_o[5])
        else $error("irq six pin driven");
    a_irq_gated: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_05]
        !$past(func_sel[5])
        |-> !ext_irq_six_o)
        else $error("irq six in port mode");
    a_reload_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_06]
        timer2_reload_o
        |-> $past(func_sel[6]) && $past(t2_ctrl[3]) && !$past(port_e_pin_i[6]))
        else $error("reload without cause");
    a_reload_edge: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_06]
        func_sel[6] && t2_ctrl[3] && !port_e_pin_i[6] && $past(port_e_pin_i[6])
        |=> timer2_reload_o)
        else $error("reload missed");
    a_reload_single: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_06]
        timer2_reload_o
        |=> !timer2_reload_o)
        else $error("reload longer than one cycle");
    a_reload_input: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_06]
        $past(func_sel[6])
        |-> !port_e_pin_oe_o[6])
        else $error("reload pin driven");
    a_reload_off: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_06]
        !$past(t2_ctrl[3])
        |-> !timer2_reload_o)
        else $error("reload while disabled");
    a_addr8_out: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_07]
        $past(func_sel[7])
        |-> port_e_pin_oe_o[7] && port_e_pin_o[7] == $past(waveform_addr_bit8_i))
        else $error("address bit 8 wrong");
    a_rd_strobe: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_09]
        $past(slave_mode)
        |-> slave_read_strobe_o == ($past(ready_in_i[0]) == $past(fifo_pol[3])))
        else $error("read strobe polarity");
    a_rd_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_09]
        !$past(slave_mode)
        |-> !slave_read_strobe_o && waveform_ready_o[0] == $past(ready_in_i[0]))
        else $error("read strobe in ready mode");
    a_wr_strobe: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_10]
        !$past(slave_mode)
        |-> !slave_write_strobe_o && waveform_ready_o[1] == $past(ready_in_i[1]))
        else $error("write strobe in ready mode");
    a_wr_polarity: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_10]
        $past(slave_mode)
        |-> slave_write_strobe_o == ($past(ready_in_i[1]) == $past(fifo_pol[2])))
        else $error("write strobe polarity");
    a_rdy_pass: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_11]
        1'b1
        |-> waveform_ready_o[5:2] == $past(ready_in_i[5:2]))
        else $error("ready 2..5 not passed");
    a_rdy_masked: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_08]
        $past(slave_mode)
        |-> waveform_ready_o[1:0] == 2'b00)
        else $error("ready 0..1 not masked");
    a_mode_ready: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_08]
        $past(if_config[1:0]) != 2'h3
        |-> !slave_read_strobe_o && !slave_write_strobe_o)
        else $error("strobe outside slave mode");
    a_sel_port: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_01]
        !$past(func_sel[2])
        |-> port_e_pin_oe_o[2] == $past(port_oe[2]))
        else $error("port mode oe wrong");
    a_port_low: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_01]
        1'b1
        |-> port_e_pin_o[1:0] == $past(port_out[1:0]) && port_e_pin_oe_o[1:0] == $past(port_oe[1:0]))
        else $error("pins 0..1 not plain port");
    a_addr8_port: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_01]
        !$past(func_sel[7])
        |-> port_e_pin_o[7] == $past(port_out[7]) && port_e_pin_oe_o[7] == $past(port_oe[7]))
        else $error("pin 7 port mode wrong");
    a_ser0_port: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_01]
        !$past(func_sel[3])
        |-> port_e_pin_o[3] == $past(port_out[3]) && port_e_pin_oe_o[3] == $past(port_oe[3]))
        else $error("pin 3 port mode wrong");
    a_reset_inputs: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RULE_13]
        $rose(rst_b_i)
        |-> port_e_pin_oe_o == 8'h00 && func_sel == 8'h00)
        else $error("pins not inputs after reset");
endmodule

// ### tb/pemx_far_model.sv
// Far-side parallel logic model driving the port E input pins and the ready lines.
`timescale 1ns/1ps
module pemx_far_model (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic [7:0] pin_o_i,
    input  wire logic [7:0] pin_oe_i,
    input  wire logic [1:0] lvl_i,
    input  wire logic [5:0] rdy_i,
    input  wire logic       slave_i,
    input  wire logic [1:0] act_i,
    input  wire logic [1:0] pol_i,
    output logic      [7:0] pin_lvl_o,
    output logic      [5:0] ready_o
);
    logic [1:0] lvl_ff;
    logic [5:0] rdy_ff;
    logic       tog_ff;
    // Undriven pins other than 5 and 6 toggle every cycle so a stale level can never pass for a driven one; pins 5 and 6 follow lvl.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lvl_ff <= 2'h0;
            rdy_ff <= 6'h00;
            tog_ff <= 1'b0;
        end else begin
            lvl_ff <= lvl_i;
            tog_ff <= ~tog_ff;
            if (slave_i) begin
                rdy_ff <= {rdy_i[5:2], act_i[1] ~^ pol_i[1], act_i[0] ~^ pol_i[0]};
            end else begin
                rdy_ff <= rdy_i;
            end
        end
    end
    assign pin_lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & {1'b0, lvl_ff, 5'h00})
                     | (~pin_oe_i & 8'h9f & {8{tog_ff}});
    assign ready_o   = rdy_ff;
endmodule

// ### tb/test_port_e_and_ready_pin_mux.sv
// Self-checking testbench of the port E and ready pin multiplexer.
`timescale 1ns/1ps
`include "pemx_defs.svh"
`define PEMX_CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module test_port_e_and_ready_pin_mux;
    logic        clk_i = 1'b0;
    logic        rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, slave;
    logic        timer2_overflow_i, serial0_data_i, serial1_data_i, waveform_addr_bit8_i;
    logic        ext_irq_six_o, timer2_reload_o, slave_read_strobe_o, slave_write_strobe_o;
    logic [1:0]  serial0_mode_i, serial1_mode_i, lvl, act, pol;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic [7:0]  port_e_pin_i, port_e_pin_o, port_e_pin_oe_o;
    logic [5:0]  ready_in_i, waveform_ready_o, rdy;
    logic [2:0]  pls;
    int          errors, comparisons;
    assign pls = {timer2_reload_o, ext_irq_six_o, port_e_pin_o[2]};
    always #5 clk_i = ~clk_i;
    pemx_port_e_mux DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .port_e_pin_i(port_e_pin_i), .port_e_pin_o(port_e_pin_o),
        .port_e_pin_oe_o(port_e_pin_oe_o), .timer2_overflow_i(timer2_overflow_i),
        .serial0_data_i(serial0_data_i), .serial0_mode_i(serial0_mode_i), .serial1_data_i(serial1_data_i),
        .serial1_mode_i(serial1_mode_i), .waveform_addr_bit8_i(waveform_addr_bit8_i),
        .ext_irq_six_o(ext_irq_six_o), .timer2_reload_o(timer2_reload_o), .ready_in_i(ready_in_i),
        .waveform_ready_o(waveform_ready_o), .slave_read_strobe_o(slave_read_strobe_o),
        .slave_write_strobe_o(slave_write_strobe_o));
    pemx_far_model far (.clk_i(clk_i), .rst_b_i(rst_b_i), .pin_o_i(port_e_pin_o), .pin_oe_i(port_e_pin_oe_o),
        .lvl_i(lvl), .rdy_i(rdy), .slave_i(slave), .act_i(act), .pol_i(pol), .pin_lvl_o(port_e_pin_i),
        .ready_o(ready_in_i));
    task automatic end_of_test();
        $display("Comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // The request is held until pready is seen high; the idle edge after it keeps transfers apart.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (pready_o !== 1'b1) begin
            errors++;
            end_of_test();
        end
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic chk_rd(input logic [11:0] a, input logic [31:0] ex, input logic ex_err);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        `PEMX_CHK("read data", ex, q)
        `PEMX_CHK("slave error", ex_err, e)
    endtask
    task automatic count(input int sel, input int win, output int c);
        c = 0;
        repeat (win) begin
            @(posedge clk_i);
            if (pls[sel] === 1'b1) c++;
        end
    endtask
    task automatic t_port();
        wr(`PEMX_OFF_PORT_OUT, 32'ha5);
        wr(`PEMX_OFF_PORT_OE, 32'hfc);
        cyc(3);
        `PEMX_CHK("port drive", 6'h29, port_e_pin_o[7:2])
        `PEMX_CHK("port enable", 6'h3f, port_e_pin_oe_o[7:2])
        wr(`PEMX_OFF_FUNC_SEL, 32'hff);
        chk_rd(`PEMX_OFF_FUNC_SEL, 32'hfc, 1'b0);
        for (int b = 1; b >= 0; b--) begin
            waveform_addr_bit8_i <= b[0];
            cyc(3);
            `PEMX_CHK("address bit", b[0], port_e_pin_o[7])
        end
        `PEMX_CHK("alternate enables", 3'b100, port_e_pin_oe_o[7:5])
    endtask
    task automatic t_serial();
        for (int m = 0; m < 4; m++) begin
            for (int d = 0; d < 2; d++) begin
                serial0_mode_i <= m[1:0];
                serial1_mode_i <= m[1:0];
                serial0_data_i <= d[0];
                serial1_data_i <= d[0];
                cyc(3);
                `PEMX_CHK("serial0 pin", (m == 0) ? d[0] : 1'b1, port_e_pin_o[3])
                `PEMX_CHK("serial1 pin", (m == 0) ? d[0] : 1'b1, port_e_pin_o[4])
            end
        end
    endtask
    task automatic t_edges();
        int c;
        timer2_overflow_i <= 1'b1;
        @(posedge clk_i);
        timer2_overflow_i <= 1'b0;
        count(0, 6, c);
        `PEMX_CHK("overflow pulse", 1, c)
        lvl <= 2'b01;
        count(1, 8, c);
        `PEMX_CHK("irq rise", 1, c)
        lvl <= 2'b10;
        count(1, 8, c);
        `PEMX_CHK("irq fall", 0, c)
        lvl <= 2'b00;
        count(2, 8, c);
        `PEMX_CHK("reload disabled", 0, c)
        wr(`PEMX_OFF_TIMER2_CTRL, 32'h1 << `PEMX_T2_EXEN_BIT);
        lvl <= 2'b10;
        cyc(3);
        lvl <= 2'b00;
        count(2, 8, c);
        `PEMX_CHK("reload enabled", 1, c)
    endtask
    task automatic t_ready();
        rdy <= 6'h2a;
        for (int m = 0; m < 3; m++) begin
            wr(`PEMX_OFF_IF_CONFIG, m);
            cyc(3);
            `PEMX_CHK("ready path", 6'h2a, waveform_ready_o)
        end
        wr(`PEMX_OFF_IF_CONFIG, 32'h3);
        slave <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            for (int a = 0; a < 2; a++) begin
                wr(`PEMX_OFF_FIFO_POL, (p << `PEMX_POL_RD_BIT) | ((1 - p) << `PEMX_POL_WR_BIT));
                pol <= {~p[0], p[0]};
                act <= {~a[0], a[0]};
                cyc(3);
                `PEMX_CHK("read strobe", a[0], slave_read_strobe_o)
                `PEMX_CHK("write strobe", ~a[0], slave_write_strobe_o)
                `PEMX_CHK("ready upper", 4'ha, waveform_ready_o[5:2])
                `PEMX_CHK("ready lower", 2'b00, waveform_ready_o[1:0])
            end
        end
        chk_rd(`PEMX_OFF_STATUS, 32'h4, 1'b0);
    endtask
    initial begin
        {rst_b_i, psel_i, penable_i, pwrite_i, timer2_overflow_i, serial0_data_i, serial1_data_i} = '0;
        {waveform_addr_bit8_i, serial0_mode_i, serial1_mode_i, lvl, act, pol, slave, rdy} = '0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        errors = 0;
        comparisons = 0;
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        cyc(2);
        `PEMX_CHK("reset enables", 8'h00, port_e_pin_oe_o)
        chk_rd(`PEMX_OFF_FUNC_SEL, 32'h0, 1'b0);
        chk_rd(12'h020, 32'h0, 1'b1);
        t_port();
        t_serial();
        t_edges();
        t_ready();
        end_of_test();
    end
endmodule
